// ### hdl/obc_top.sv
// Operation
// - Debug link writes any option byte through its option-area address.
// - Application writes accepted; readout and boot-area changes only via debug link.
// - Readout byte at first location, 0xAA means protection off, factory 0xAA.
// - Boot area 0x00 means none, 0x01 means vectors only.
// - Boot area 0x02 read/write protects pages; 0x03 and up write protect.
// - Independent watchdog hardware start bit starts it at load.
// - Independent watchdog halt bit set stops it in halt modes.
// - Window watchdog hardware start bit starts it at load.
// - Window watchdog halt bit set issues reset on halt entry.
// - Fast oscillator settle field selects 1, 16, 512 or 4096 cycles.
// - Slow oscillator settle field uses the same encoding.
// - Reference trim byte read-only, upper bits fixed 0x6; the code returns REFVOLT_TRIM whole (default 0x5A).
// - Temperature trim byte read-only, top bits fixed 0x3; the code returns TEMPSENSE_TRIM whole (default 0xA5).
// - Loading starts only after supply passes the brownout threshold.
//
// Option byte store with application and debug-link ports, loaded once after reset.
// Assumes power_good and halt_entry come from other clock domains and are synchronised here;
// the two request ports are on ref_clk.
`timescale 1ns/1ps
`include "obc_cfg.svh"
module obc_top
    import obc_pkg::*;
#(
    parameter logic [7:0] REFVOLT_TRIM   = 8'h5A, // Factory value, arbitrary default
    parameter logic [7:0] TEMPSENSE_TRIM = 8'hA5  // Factory value, arbitrary default
)(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       power_good,
    input  wire logic       halt_entry,
    input  wire obc_req_t   app_req,
    output logic [7:0]      app_rdata,
    output logic            app_rvalid,
    input  wire obc_req_t   dbg_req,
    output logic [7:0]      dbg_rdata,
    output logic            dbg_rvalid,
    output logic            dbg_read_blocked,
    output obc_cfg_t        cfg,
    output logic            cfg_valid,
    output logic            fast_osc_ready,
    output logic            slow_osc_ready,
    output logic            window_watchdog_reset
);
    // Stored option bytes (non-volatile image)
    logic [7:0] readout_byte;
    logic [7:0] boot_byte;
    logic [7:0] wdog_byte;
    logic [7:0] osc_byte;
    logic [7:0] bor_byte;
    logic [7:0] loader_lo;
    logic [7:0] loader_hi;
    logic [7:0] next_readout_byte;
    logic [7:0] next_boot_byte;
    logic [7:0] next_wdog_byte;
    logic [7:0] next_osc_byte;
    logic [7:0] next_bor_byte;
    logic [7:0] next_loader_lo;
    logic [7:0] next_loader_hi;

    // Synchronisers for asynchronous inputs
    logic       pg_meta;
    logic       pg_sync;
    logic       halt_meta;
    logic       halt_sync;

    obc_state_t state;
    obc_state_t next_state;
    obc_cfg_t   next_cfg;
    logic       next_cfg_valid;
    logic       settle_start;
    logic       next_settle_start;
    logic       protected_now;

    logic [7:0] next_app_rdata;
    logic       next_app_rvalid;
    logic [7:0] next_dbg_rdata;
    logic       next_dbg_rvalid;
    logic       next_dbg_read_blocked;
    logic       next_wwdg_reset;

    // Two-stage synchronisers; first stage read by the second only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pg_meta   <= 1'b0;
            pg_sync   <= 1'b0;
            halt_meta <= 1'b0;
            halt_sync <= 1'b0;
        end else begin
            pg_meta   <= power_good;
            pg_sync   <= pg_meta;
            halt_meta <= halt_entry;
            halt_sync <= halt_meta;
        end
    end

    // Read mux shared by both ports; trim bytes return the whole parameter values
    function automatic logic [7:0] read_opt(input logic [15:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            `OBC_OFS_READOUT:   d = readout_byte;
            `OBC_OFS_BOOTAREA:  d = boot_byte;
            `OBC_OFS_WATCHDOG:  d = wdog_byte;
            `OBC_OFS_OSC:       d = osc_byte;
            `OBC_OFS_BROWNOUT:  d = bor_byte;
            `OBC_OFS_LOADER_LO: d = loader_lo;
            `OBC_OFS_LOADER_HI: d = loader_hi;
            `OBC_OFS_REFVOLT:   d = REFVOLT_TRIM;
            `OBC_OFS_TEMPSENSE: d = TEMPSENSE_TRIM;
            default:            d = 8'h00;          // Reserved and unmapped read zero
        endcase
        return d;
    endfunction

    assign protected_now = (readout_byte != `OBC_READOUT_OFF);

    // Option store writes: debug link has priority over the application
    always_comb begin
        next_readout_byte = readout_byte;
        next_boot_byte    = boot_byte;
        next_wdog_byte    = wdog_byte;
        next_osc_byte     = osc_byte;
        next_bor_byte     = bor_byte;
        next_loader_lo    = loader_lo;
        next_loader_hi    = loader_hi;
        if (app_req.wr && !dbg_req.wr) begin
            // Readout and boot-area bytes cannot change from the application
            unique case (app_req.addr)
                `OBC_OFS_WATCHDOG:  next_wdog_byte = app_req.wdata;
                `OBC_OFS_OSC:       next_osc_byte  = app_req.wdata;
                `OBC_OFS_BROWNOUT:  next_bor_byte  = app_req.wdata;
                `OBC_OFS_LOADER_LO: next_loader_lo = app_req.wdata;
                `OBC_OFS_LOADER_HI: next_loader_hi = app_req.wdata;
                default: ;
            endcase
        end
        if (dbg_req.wr) begin
            unique case (dbg_req.addr)
                `OBC_OFS_READOUT:   next_readout_byte = dbg_req.wdata;
                `OBC_OFS_BOOTAREA:  next_boot_byte    = dbg_req.wdata;
                `OBC_OFS_WATCHDOG:  next_wdog_byte    = dbg_req.wdata;
                `OBC_OFS_OSC:       next_osc_byte     = dbg_req.wdata;
                `OBC_OFS_BROWNOUT:  next_bor_byte     = dbg_req.wdata;
                `OBC_OFS_LOADER_LO: next_loader_lo    = dbg_req.wdata;
                `OBC_OFS_LOADER_HI: next_loader_hi    = dbg_req.wdata;
                default: ;
            endcase
        end
    end

    // Store returns to factory values on the block reset in this model
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            readout_byte <= `OBC_RST_READOUT;
            boot_byte    <= `OBC_RST_BOOTAREA;
            wdog_byte    <= `OBC_RST_WATCHDOG;
            osc_byte     <= `OBC_RST_OSC;
            bor_byte     <= `OBC_RST_BROWNOUT;
            loader_lo    <= `OBC_RST_LOADER;
            loader_hi    <= `OBC_RST_LOADER;
        end else begin
            readout_byte <= next_readout_byte;
            boot_byte    <= next_boot_byte;
            wdog_byte    <= next_wdog_byte;
            osc_byte     <= next_osc_byte;
            bor_byte     <= next_bor_byte;
            loader_lo    <= next_loader_lo;
            loader_hi    <= next_loader_hi;
        end
    end

    // Read answers one cycle after the request; debug reads blocked while protected
    always_comb begin
        next_app_rdata        = app_req.rd ? read_opt(app_req.addr) : app_rdata;
        next_app_rvalid       = app_req.rd;
        next_dbg_rvalid       = dbg_req.rd;
        next_dbg_read_blocked = dbg_req.rd && protected_now;
        next_dbg_rdata        = dbg_rdata;
        if (dbg_req.rd) begin
            next_dbg_rdata = protected_now ? 8'h00 : read_opt(dbg_req.addr);
        end
    end

    // Load sequence: wait for supply, latch once, then run
    always_comb begin
        next_state        = state;
        next_cfg          = cfg;
        next_cfg_valid    = cfg_valid;
        next_settle_start = 1'b0;
        unique case (state)
            OBC_ST_WAIT: begin
                if (pg_sync) begin
                    next_state = OBC_ST_LOAD;
                end
            end
            OBC_ST_LOAD: begin
                // Reserved bits are not decoded
                next_cfg.readout_protected          = protected_now;
                next_cfg.user_boot_area_size        = boot_byte;
                next_cfg.boot_vectors_only          = (boot_byte == `OBC_BOOT_VECTORS);
                next_cfg.boot_rw_protect            = (boot_byte == `OBC_BOOT_RWPROT);
                next_cfg.boot_w_protect             = (boot_byte > `OBC_BOOT_RWPROT);
                next_cfg.indep_watchdog_hw_start    = wdog_byte[`OBC_BIT_INDEP_WATCHDOG_HW_START];
                next_cfg.indep_watchdog_halt_stop   = wdog_byte[`OBC_BIT_INDEP_WATCHDOG_HALT_STOP];
                next_cfg.window_watchdog_hw_start   = wdog_byte[`OBC_BIT_WINDOW_WATCHDOG_HW_START];
                next_cfg.window_watchdog_halt_reset = wdog_byte[`OBC_BIT_WINDOW_WATCHDOG_HALT_RESET];
                next_cfg.fast_osc_settle_count = osc_byte[`OBC_POS_FAST_CNT +: 2];
                next_cfg.slow_osc_settle_count = osc_byte[`OBC_POS_SLOW_CNT +: 2];
                next_cfg.brownout_enable       = bor_byte[`OBC_BIT_BOR_EN];
                next_cfg.brownout_level        = bor_byte[`OBC_POS_BOR_LVL +: 3];
                next_cfg.loader_option_word    = {loader_hi, loader_lo};
                next_cfg_valid    = 1'b1;
                next_settle_start = 1'b1;
                next_state        = OBC_ST_RUN;
            end
            OBC_ST_RUN: ;
        endcase
    end

    // Window watchdog reset request on halt entry when so configured
    assign next_wwdg_reset = cfg_valid && cfg.window_watchdog_halt_reset && halt_sync;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state                 <= OBC_ST_WAIT;
            cfg                   <= '0;
            cfg_valid             <= 1'b0;
            settle_start          <= 1'b0;
            app_rdata             <= 8'h00;
            app_rvalid            <= 1'b0;
            dbg_rdata             <= 8'h00;
            dbg_rvalid            <= 1'b0;
            dbg_read_blocked      <= 1'b0;
            window_watchdog_reset <= 1'b0;
        end else begin
            state                 <= next_state;
            cfg                   <= next_cfg;
            cfg_valid             <= next_cfg_valid;
            settle_start          <= next_settle_start;
            app_rdata             <= next_app_rdata;
            app_rvalid            <= next_app_rvalid;
            dbg_rdata             <= next_dbg_rdata;
            dbg_rvalid            <= next_dbg_rvalid;
            dbg_read_blocked      <= next_dbg_read_blocked;
            window_watchdog_reset <= next_wwdg_reset;
        end
    end

    // One counter per oscillator; both use the same encoding
    obc_settle u_fast_settle (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .start   (settle_start),
        .sel     (cfg.fast_osc_settle_count),
        .ready   (fast_osc_ready)
    );

    obc_settle u_slow_settle (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .start   (settle_start),
        .sel     (cfg.slow_osc_settle_count),
        .ready   (slow_osc_ready)
    );

    // Assertions
    property p_dbg_write_readout;
        @(posedge ref_clk) disable iff (!rstn)
        dbg_req.wr && dbg_req.addr == `OBC_OFS_READOUT |=> readout_byte == $past(dbg_req.wdata);
    endproperty
    a_dbg_write_readout: assert property (p_dbg_write_readout)
        else $error("debug write to readout byte lost");

    property p_app_no_readout;
        @(posedge ref_clk) disable iff (!rstn)
        app_req.wr && !dbg_req.wr && app_req.addr == `OBC_OFS_READOUT |=> $stable(readout_byte);
    endproperty
    a_app_no_readout: assert property (p_app_no_readout)
        else $error("application changed readout byte");

    property p_load_after_power;
        @(posedge ref_clk) disable iff (!rstn)
        !pg_sync |=> !cfg_valid || $past(cfg_valid);
    endproperty
    a_load_after_power: assert property (p_load_after_power)
        else $error("options loaded before supply good");

    property p_latch_once;
        @(posedge ref_clk) disable iff (!rstn)
        cfg_valid |=> cfg_valid && $stable(cfg);
    endproperty
    a_latch_once: assert property (p_latch_once)
        else $error("configuration changed after load");

    property p_protect_block;
        @(posedge ref_clk) disable iff (!rstn)
        dbg_req.rd && readout_byte != `OBC_READOUT_OFF |=> dbg_read_blocked && dbg_rdata == 8'h00;
    endproperty
    a_protect_block: assert property (p_protect_block)
        else $error("protected debug read not blocked");

    property p_boot_decode;
        @(posedge ref_clk) disable iff (!rstn)
        cfg_valid |-> (cfg.boot_rw_protect == (cfg.user_boot_area_size == `OBC_BOOT_RWPROT))
            && (cfg.boot_w_protect == (cfg.user_boot_area_size > `OBC_BOOT_RWPROT));
    endproperty
    a_boot_decode: assert property (p_boot_decode)
        else $error("boot area protection decode wrong");

    property p_fast_settle16;
        @(posedge ref_clk) disable iff (!rstn)
        // Ready is a level that only start clears, so one low sample at the end covers the span
        settle_start && cfg.fast_osc_settle_count == 2'h1
            |-> ##16 !fast_osc_ready ##1 fast_osc_ready;
    endproperty
    a_fast_settle16: assert property (p_fast_settle16)
        else $error("fast oscillator settle count wrong");

    property p_wwdg_reset;
        @(posedge ref_clk) disable iff (!rstn)
        cfg_valid && cfg.window_watchdog_halt_reset && halt_sync |=> window_watchdog_reset;
    endproperty
    a_wwdg_reset: assert property (p_wwdg_reset)
        else $error("window watchdog halt reset missing");
endmodule

// ### hdl/obc_cfg.svh
// Option byte configuration block: offsets, field positions, reset values, timing counts.
// Assumes inclusion by the package and by the main module; definitions only.
`ifndef OBC_CFG_SVH
`define OBC_CFG_SVH

// Option area offsets in the data EEPROM address space
`define OBC_OFS_READOUT   16'h4800
`define OBC_OFS_BOOTAREA  16'h4802
`define OBC_OFS_RESERVED  16'h4807
`define OBC_OFS_WATCHDOG  16'h4808
`define OBC_OFS_OSC       16'h4809
`define OBC_OFS_BROWNOUT  16'h480A
`define OBC_OFS_LOADER_LO 16'h480B
`define OBC_OFS_LOADER_HI 16'h480C
`define OBC_OFS_REFVOLT   16'h4910
`define OBC_OFS_TEMPSENSE 16'h4911

// Factory settings
`define OBC_RST_READOUT   8'hAA
`define OBC_RST_BOOTAREA  8'h00
`define OBC_RST_WATCHDOG  8'h00
`define OBC_RST_OSC       8'h00
`define OBC_RST_BROWNOUT  8'h01
`define OBC_RST_LOADER    8'h00

// Codes
`define OBC_READOUT_OFF   8'hAA
`define OBC_BOOT_NONE     8'h00
`define OBC_BOOT_VECTORS  8'h01
`define OBC_BOOT_RWPROT   8'h02
`define OBC_REFVOLT_MSB   4'h6
`define OBC_TEMPSENSE_MSB 2'h3

// Field positions
`define OBC_BIT_INDEP_WATCHDOG_HW_START   0
`define OBC_BIT_INDEP_WATCHDOG_HALT_STOP 1
`define OBC_BIT_WINDOW_WATCHDOG_HW_START   2
`define OBC_BIT_WINDOW_WATCHDOG_HALT_RESET 3
`define OBC_POS_FAST_CNT  0
`define OBC_POS_SLOW_CNT  2
`define OBC_BIT_BOR_EN    0
`define OBC_POS_BOR_LVL   1

// Settle counts in clock cycles
`define OBC_SETTLE_0      13'h0001
`define OBC_SETTLE_1      13'h0010
`define OBC_SETTLE_2      13'h0200
`define OBC_SETTLE_3      13'h1000

`endif

// ### hdl/obc_pkg.sv
// Option byte configuration block: shared types.
// Assumes obc_cfg.svh is on the include path.
package obc_pkg;
    `include "obc_cfg.svh"

    // Decoded configuration outputs
    typedef struct packed {
        logic       readout_protected;
        logic [7:0] user_boot_area_size;
        logic       boot_vectors_only;
        logic       boot_rw_protect;
        logic       boot_w_protect;
        logic       indep_watchdog_hw_start;
        logic       indep_watchdog_halt_stop;
        logic       window_watchdog_hw_start;
        logic       window_watchdog_halt_reset;
        logic [1:0] fast_osc_settle_count;
        logic [1:0] slow_osc_settle_count;
        logic       brownout_enable;
        logic [2:0] brownout_level;
        logic [15:0] loader_option_word;
    } obc_cfg_t;

    // Option memory access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } obc_req_t;

    typedef enum logic [1:0] {
        OBC_ST_WAIT,
        OBC_ST_LOAD,
        OBC_ST_RUN
    } obc_state_t;
endpackage

// ### hdl/obc_settle.sv
// Oscillator settle counter: counts the selected number of cycles after start.
// Assumes start is a one-cycle pulse on ref_clk.
`timescale 1ns/1ps
`include "obc_cfg.svh"
module obc_settle
    import obc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       start,
    input  wire logic [1:0] sel,
    output logic            ready
);
    logic [12:0] cnt;
    logic [12:0] next_cnt;
    logic        next_ready;

    // Load the count on start, run down to one, then flag ready
    always_comb begin
        next_cnt   = cnt;
        next_ready = ready;
        if (start) begin
            unique case (sel)
                2'h0: next_cnt = `OBC_SETTLE_0;
                2'h1: next_cnt = `OBC_SETTLE_1;
                2'h2: next_cnt = `OBC_SETTLE_2;
                2'h3: next_cnt = `OBC_SETTLE_3;
            endcase
            next_ready = 1'b0;
        end else if (cnt > 13'h0001) begin
            next_cnt = cnt - 13'h0001;
        end else if (cnt == 13'h0001) begin
            next_cnt   = 13'h0000;
            next_ready = 1'b1; // Ready one cycle after the last counted cycle
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt   <= 13'h0000;
            ready <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            ready <= next_ready;
        end
    end
endmodule

// ### testbench/obc_prog_tool.sv
// External programming tool model on the debug link of the option byte block.
// Assumes the testbench calls its tasks and that requests live on ref_clk.
`timescale 1ns/1ps
module obc_prog_tool
    import obc_pkg::*;
(
    input  wire logic       ref_clk,
    output obc_req_t        dbg_req,
    input  wire logic [7:0] dbg_rdata,
    input  wire logic       dbg_rvalid,
    input  wire logic       dbg_read_blocked
);
    initial dbg_req = '0;

    // Released lines show the inverse of the last request, so stale data never looks valid
    task automatic release_bus();
        dbg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~dbg_req.addr, wdata: ~dbg_req.wdata};
    endtask

    // One write pulse into the option area, after gap idle cycles
    task automatic write(input logic [15:0] addr, input logic [7:0] data, input int gap);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        dbg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge ref_clk);
        release_bus();
    endtask

    // One read pulse; the answer comes one cycle later and stands one cycle
    task automatic read(input logic [15:0] addr, output logic [7:0] data,
                        output logic blk, output logic vld);
        @(posedge ref_clk);
        dbg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge ref_clk);
        release_bus();
        #1;
        vld  = dbg_rvalid;
        data = dbg_rdata;
        blk  = dbg_read_blocked;
    endtask
endmodule

// ### testbench/test_option_byte_config.sv
// Self-checking testbench of the option byte block with a debug-link tool model.
// Assumes the design's package and header are compiled first.
`timescale 1ns/1ps
`include "obc_cfg.svh"
module test_option_byte_config import obc_pkg::*;;
    logic       ref_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       power_good = 1'b0;
    logic       halt_entry = 1'b0;
    obc_req_t   app_req = '0;
    logic [7:0] app_rdata;
    logic       app_rvalid;
    obc_req_t   dbg_req;
    logic [7:0] dbg_rdata;
    logic       dbg_rvalid;
    logic       dbg_read_blocked;
    obc_cfg_t   cfg;
    logic       cfg_valid;
    logic       fast_osc_ready;
    logic       slow_osc_ready;
    logic       window_watchdog_reset;
    int         bad_count = 0;
    int         n_checks = 0;

    // 250 MHz system clock
    always #2 ref_clk = ~ref_clk;

    obc_top uut (.ref_clk(ref_clk), .rstn(rstn), .power_good(power_good),
        .halt_entry(halt_entry), .app_req(app_req), .app_rdata(app_rdata),
        .app_rvalid(app_rvalid), .dbg_req(dbg_req), .dbg_rdata(dbg_rdata),
        .dbg_rvalid(dbg_rvalid), .dbg_read_blocked(dbg_read_blocked), .cfg(cfg),
        .cfg_valid(cfg_valid), .fast_osc_ready(fast_osc_ready),
        .slow_osc_ready(slow_osc_ready), .window_watchdog_reset(window_watchdog_reset));

    obc_prog_tool tool (.ref_clk(ref_clk), .dbg_req(dbg_req), .dbg_rdata(dbg_rdata),
        .dbg_rvalid(dbg_rvalid), .dbg_read_blocked(dbg_read_blocked));

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Application access; the answer of a read stands one cycle after the request
    task automatic app_rw(input logic wr, input logic [15:0] addr, input logic [7:0] data,
                          output logic [7:0] rdata);
        @(posedge ref_clk);
        app_req <= '{wr: wr, rd: ~wr, addr: addr, wdata: data};
        @(posedge ref_clk);
        app_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
        #1;
        rdata = app_rdata;
        if (!wr) check(app_rvalid, 1'b1);
    endtask

    // Reset held two cycles with the supply still below threshold
    task automatic start_up();
        @(posedge ref_clk);
        rstn <= 1'b0;
        power_good <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
    endtask

    // Supply passes the threshold; options load within a bounded wait
    task automatic load();
        int k;
        @(posedge ref_clk);
        power_good <= 1'b1;
        for (k = 0; k < 20 && cfg_valid !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        check(cfg_valid, 1'b1);
    endtask

    function automatic int settle(input logic [1:0] code);
        return (code == 2'b00) ? 1 : (code == 2'b01) ? 16 : (code == 2'b10) ? 512 : 4096;
    endfunction

    // Factory values, read-only trims, reserved and unmapped reads, load gated by supply
    task automatic test_factory();
        logic [15:0] adr [11] = '{16'h4800, 16'h4802, 16'h4807, 16'h4808, 16'h4809,
            16'h480A, 16'h480B, 16'h480C, 16'h4910, 16'h4911, 16'h4000};
        logic [7:0]  val [11] = '{8'hAA, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
            8'h5A, 8'hA5, 8'h00};
        logic [7:0] d;
        logic b, v;
        start_up();
        repeat (10) @(posedge ref_clk);
        #1 check(cfg_valid, 1'b0);
        foreach (adr[i]) begin
            app_rw(1'b0, adr[i], 8'h00, d);
            check(d, val[i]);
        end
        app_rw(1'b1, `OBC_OFS_READOUT, 8'h00, d);
        app_rw(1'b1, `OBC_OFS_BOOTAREA, 8'h05, d);
        app_rw(1'b1, `OBC_OFS_WATCHDOG, 8'h0C, d);
        app_rw(1'b1, `OBC_OFS_REFVOLT, 8'h00, d);
        app_rw(1'b0, `OBC_OFS_READOUT, 8'h00, d);
        check(d, 8'hAA);
        app_rw(1'b0, `OBC_OFS_BOOTAREA, 8'h00, d);
        check(d, 8'h00);
        app_rw(1'b0, `OBC_OFS_WATCHDOG, 8'h00, d);
        check(d, 8'h0C);
        app_rw(1'b0, `OBC_OFS_REFVOLT, 8'h00, d);
        check(d, 8'h5A);
        tool.read(`OBC_OFS_READOUT, d, b, v);
        check({v, b, d}, {2'b10, 8'hAA});
        $display("factory test done");
    endtask

    // Programmed options decode, settle counts, halt reset, once-per-reset latching
    task automatic test_programmed();
        logic [7:0] readout_protect_byte [4] = '{8'hAA, 8'h00, 8'h55, 8'hAA};
        logic [7:0] boot [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
        logic [7:0] wd [4] = '{8'hF0, 8'hF5, 8'hFA, 8'h0F};
        logic [7:0] bor [4] = '{8'h01, 8'h0E, 8'h07, 8'hF0};
        obc_cfg_t exp;
        logic [7:0] d, osc;
        logic b, v;
        int c, fr, sr;
        for (int i = 0; i < 4; i++) begin
            start_up();
            osc = 8'hF0 | 8'((3 - i) << 2) | 8'(i);
            tool.write(`OBC_OFS_READOUT, readout_protect_byte[i], i);
            tool.write(`OBC_OFS_BOOTAREA, boot[i], 0);
            tool.write(`OBC_OFS_WATCHDOG, wd[i], 0);
            tool.write(`OBC_OFS_OSC, osc, 0);
            tool.write(`OBC_OFS_BROWNOUT, bor[i], 0);
            tool.write(`OBC_OFS_LOADER_LO, 8'h12 + 8'(i), 0);
            tool.write(`OBC_OFS_LOADER_HI, 8'h9A - 8'(i), 0);
            app_rw(1'b1, `OBC_OFS_READOUT, 8'hAA, d);
            app_rw(1'b1, `OBC_OFS_BOOTAREA, 8'h00, d);
            tool.read(`OBC_OFS_LOADER_LO, d, b, v);
            check({v, b, d}, (readout_protect_byte[i] != 8'hAA) ? 10'h300 : {2'b10, 8'h12 + 8'(i)});
            exp = '0;
            exp.readout_protected = (readout_protect_byte[i] != 8'hAA);
            exp.user_boot_area_size = boot[i];
            exp.boot_vectors_only = (boot[i] == 8'h01);
            exp.boot_rw_protect = (boot[i] == 8'h02);
            exp.boot_w_protect = (boot[i] >= 8'h03);
            exp.indep_watchdog_hw_start = wd[i][0];
            exp.indep_watchdog_halt_stop = wd[i][1];
            exp.window_watchdog_hw_start = wd[i][2];
            exp.window_watchdog_halt_reset = wd[i][3];
            exp.fast_osc_settle_count = 2'(i);
            exp.slow_osc_settle_count = 2'(3 - i);
            exp.brownout_enable = bor[i][0];
            exp.brownout_level = bor[i][3:1];
            exp.loader_option_word = {8'h9A - 8'(i), 8'h12 + 8'(i)};
            load();
            check(cfg, exp);
            fr = 0;
            sr = 0;
            for (c = 1; c < 4200 && (fr == 0 || sr == 0); c++) begin
                @(posedge ref_clk);
                #1;
                if (fast_osc_ready === 1'b1 && fr == 0) fr = c;
                if (slow_osc_ready === 1'b1 && sr == 0) sr = c;
            end
            check(fr, settle(2'(i)) + 1);
            check(sr, settle(2'(3 - i)) + 1);
            @(posedge ref_clk);
            halt_entry <= 1'b1;
            repeat (4) @(posedge ref_clk);
            halt_entry <= 1'b0;
            #1 check(window_watchdog_reset, wd[i][3]);
            tool.write(`OBC_OFS_WATCHDOG, ~wd[i], 1);
            repeat (4) @(posedge ref_clk);
            #1 check(cfg, exp);
        end
        $display("programmed options test done");
    endtask

    // Hang guard: the whole run needs about 9500 cycles
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end

    initial begin
        test_factory();
        test_programmed();
        end_of_test();
    end
endmodule
